// [core/spram_ctrl.sv]
`timescale 1ns/1ns
module spram_ctrl
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic req_valid,
   output logic req_ready,
   input wire logic req_write,
   input wire logic req_sel_mode,
   input wire logic [spram_pkg::SPRAM_AW-1:0] req_addr,
   input wire logic [spram_pkg::SPRAM_WIDTH-1:0] req_wdata,
   output logic rsp_valid,
   output logic [spram_pkg::SPRAM_WIDTH-1:0] rsp_rdata,
   output logic [spram_pkg::SPRAM_AW-1:0] mem_addr,
   output logic [spram_pkg::SPRAM_WIDTH-1:0] mem_wdata,
   output logic ram_select_n,
   output logic write_strobe_n,
   input wire logic [spram_pkg::SPRAM_WIDTH-1:0] mem_rdata
);
   import spram_pkg::*;

   spram_state_t state_q;
   spram_state_t state_d;
   logic write_q;
   spram_mode_t mode_q;
   logic load;
   logic [3:0] load_cnt;
   logic done;
   logic sel_n_d;
   logic we_n_d;
   logic cur_write;
   spram_mode_t cur_mode;

   // request bit to phase-timing mode
   function automatic spram_mode_t mode_of(logic sel);
      return sel ? SPRAM_MODE_SEL : SPRAM_MODE_ADDR;
   endfunction

   initial
   begin
      if (SPRAM_DEPTH < SPRAM_DEPTH_MIN || SPRAM_DEPTH > SPRAM_DEPTH_MAX)
         $error("depth out of range");
      if (SPRAM_WIDTH < SPRAM_WIDTH_MIN || SPRAM_WIDTH > SPRAM_WIDTH_MAX)
         $error("width out of range");
   end

   // one counter times setup, access, strobe and hold in turn
   spram_phase_timer u_timer
   (
      .clk(clk),
      .rst_n(rst_n),
      .load(load),
      .count(load_cnt),
      .done(done)
   );

   // one request at a time on the single port
   assign req_ready = (state_q == SPRAM_IDLE);

   always_comb
   begin
      state_d = state_q;
      load = 1'b0;
      load_cnt = SPRAM_CNT_RST;
      case (state_q)
         SPRAM_IDLE:
         begin
            if (req_valid)
            begin
               state_d = SPRAM_SETUP;
               load = 1'b1;
               load_cnt = SPRAM_SETUP_CYC;
            end
         end
         SPRAM_SETUP:
         begin
            if (done)
            begin
               state_d = write_q ? SPRAM_WR : SPRAM_RD;
               load = 1'b1;
               load_cnt = write_q ? SPRAM_STROBE_CYC : SPRAM_ACCESS_CYC;
            end
         end
         SPRAM_RD:
         begin
            if (done)
               state_d = SPRAM_IDLE;
         end
         SPRAM_WR:
         begin
            if (done)
            begin
               state_d = SPRAM_HOLD;
               load = 1'b1;
               load_cnt = SPRAM_HOLD_CYC;
            end
         end
         SPRAM_HOLD:
         begin
            if (done)
               state_d = SPRAM_IDLE;
         end
         default:
            state_d = SPRAM_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         state_q <= SPRAM_IDLE;
      else
         state_q <= state_d;
   end

   // request capture; address only moves in idle
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         write_q <= 1'b0;
         mode_q <= SPRAM_MODE_ADDR;
         mem_addr <= '0;
         mem_wdata <= '0;
      end
      else if (state_q == SPRAM_IDLE && req_valid)
      begin
         write_q <= req_write;
         mode_q <= mode_of(req_sel_mode);
         mem_addr <= req_addr;
         mem_wdata <= req_wdata;
      end
   end

   // pins change at the taking edge, so in idle the request itself is decoded, not stale captures
   always_comb
   begin
      cur_write = write_q;
      cur_mode = mode_q;
      if (state_q == SPRAM_IDLE)
      begin
         cur_write = req_write;
         cur_mode = mode_of(req_sel_mode);
      end
   end

   always_comb
   begin
      sel_n_d = 1'b1;
      we_n_d = 1'b1;
      case (state_d)
         SPRAM_SETUP:
            // address-mode read keeps select low while the address settles
            sel_n_d = !(!cur_write && cur_mode == SPRAM_MODE_ADDR);
         SPRAM_RD:
            sel_n_d = 1'b0;
         SPRAM_WR:
         begin
            sel_n_d = 1'b0;
            we_n_d = 1'b0;
         end
         SPRAM_HOLD:
         begin
            // strobe-timed ends by raising strobe, select-timed by raising select
            sel_n_d = (cur_mode == SPRAM_MODE_SEL);
            we_n_d = (cur_mode == SPRAM_MODE_ADDR);
         end
         default:
         begin
            sel_n_d = 1'b1;
            we_n_d = 1'b1;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ram_select_n <= 1'b1;
         write_strobe_n <= 1'b1;
      end
      else
      begin
         ram_select_n <= sel_n_d;
         write_strobe_n <= we_n_d;
      end
   end

   // read data sampled only at the end of a read, never during writes
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rsp_valid <= 1'b0;
         rsp_rdata <= '0;
      end
      else
      begin
         rsp_valid <= 1'b0;
         if (state_q == SPRAM_RD && done)
         begin
            rsp_valid <= 1'b1;
            rsp_rdata <= mem_rdata;
         end
         else if (state_q == SPRAM_HOLD && done)
            rsp_valid <= 1'b1;
      end
   end
endmodule

// [core/spram_pkg.sv]
package spram_pkg;
   // word count and data width of the attached macro
   localparam int unsigned SPRAM_DEPTH = 2048;
   localparam int unsigned SPRAM_WIDTH = 72;
   localparam int unsigned SPRAM_AW = $clog2(SPRAM_DEPTH);
   localparam int unsigned SPRAM_DEPTH_MIN = 4;
   localparam int unsigned SPRAM_DEPTH_MAX = 2048;
   localparam int unsigned SPRAM_WIDTH_MIN = 1;
   localparam int unsigned SPRAM_WIDTH_MAX = 72;
   // clock and phase timing
   localparam int unsigned SPRAM_CLK_NS = 40;
   localparam int unsigned SPRAM_SETUP_NS = 40;
   localparam int unsigned SPRAM_ACCESS_NS = 80;
   localparam int unsigned SPRAM_STROBE_NS = 40;
   localparam int unsigned SPRAM_HOLD_NS = 40;
   localparam logic [3:0] SPRAM_SETUP_CYC = 4'((SPRAM_SETUP_NS + SPRAM_CLK_NS - 1) / SPRAM_CLK_NS);
   localparam logic [3:0] SPRAM_ACCESS_CYC = 4'((SPRAM_ACCESS_NS + SPRAM_CLK_NS - 1) / SPRAM_CLK_NS);
   localparam logic [3:0] SPRAM_STROBE_CYC = 4'((SPRAM_STROBE_NS + SPRAM_CLK_NS - 1) / SPRAM_CLK_NS);
   localparam logic [3:0] SPRAM_HOLD_CYC = 4'((SPRAM_HOLD_NS + SPRAM_CLK_NS - 1) / SPRAM_CLK_NS);
   localparam logic [3:0] SPRAM_CNT_RST = 4'h0;
   typedef enum logic [1:0] {SPRAM_MODE_ADDR, SPRAM_MODE_SEL} spram_mode_t;
   typedef enum {SPRAM_IDLE, SPRAM_SETUP, SPRAM_RD, SPRAM_WR, SPRAM_HOLD} spram_state_t;
endpackage

// [core/spram_phase_timer.sv]
`timescale 1ns/1ns
module spram_phase_timer
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic load,
   input wire logic [3:0] count,
   output logic done
);
   import spram_pkg::*;
   logic [3:0] cnt_q;
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         cnt_q <= SPRAM_CNT_RST;
      else if (load)
         cnt_q <= count - 4'h1;
      else if (cnt_q != 4'h0)
         cnt_q <= cnt_q - 4'h1;
   end
   assign done = (cnt_q == 4'h0);
endmodule

// [verif/spram_ctrl_chk.sv]
`timescale 1ns/1ns
module spram_ctrl_chk
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic req_valid,
   input wire logic req_ready,
   input wire logic req_write,
   input wire logic [spram_pkg::SPRAM_AW-1:0] mem_addr,
   input wire logic ram_select_n,
   input wire logic write_strobe_n
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire go = req_valid && req_ready;
   a_rd_strobe_high: assert property (go && !req_write |=> write_strobe_n [*4]) else $error("strobe low");
   a_rd_select_low: assert property (go && !req_write |-> ##2 !ram_select_n [*2]) else $error("no select");
   a_addr_at_sel: assert property ($fell(ram_select_n) |=> $stable(mem_addr) [*2]) else $error("addr moved");
   a_addr_no_write: assert property ($changed(mem_addr) |-> write_strobe_n) else $error("strobe low");
   a_addr_sel_high: assert property ($changed(mem_addr) |-> $past(ram_select_n)) else $error("select low");
   cover property (go && req_write);
   cover property (go && !req_write);
   cover property (go ##[5:6] go);
endmodule
bind spram_ctrl spram_ctrl_chk spram_ctrl_chk_inst
(
   .clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
   .mem_addr(mem_addr), .ram_select_n(ram_select_n), .write_strobe_n(write_strobe_n)
);

// [verif/spram_sram_model.sv]
`timescale 1ns/1ns
module spram_sram_model
(
   input wire logic [spram_pkg::SPRAM_AW-1:0] mem_addr,
   input wire logic [spram_pkg::SPRAM_WIDTH-1:0] mem_wdata,
   input wire logic ram_select_n,
   input wire logic write_strobe_n,
   output logic [spram_pkg::SPRAM_WIDTH-1:0] mem_rdata
);
   import spram_pkg::*;
   logic [SPRAM_WIDTH-1:0] cell_q [SPRAM_DEPTH];
   always @(posedge ram_select_n or posedge write_strobe_n)
      if (!ram_select_n || !write_strobe_n)
         cell_q[mem_addr] <= mem_wdata;
   always_comb
      mem_rdata = !ram_select_n && write_strobe_n ? cell_q[mem_addr] : ~cell_q[mem_addr];
endmodule

// [verif/spram_ctrl_tb.sv]
`timescale 1ns/1ns
module spram_ctrl_tb;
   import spram_pkg::*;
   logic clk = 1'h0, rst_n = 1'h0, req_valid = 1'h0, req_write = 1'h0, req_sel_mode = 1'h0;
   logic req_ready, rsp_valid, ram_select_n, write_strobe_n;
   logic [SPRAM_AW-1:0] req_addr = '0, mem_addr;
   logic [SPRAM_WIDTH-1:0] req_wdata = '0, rsp_rdata, mem_wdata, mem_rdata, ref_q [int];
   int bad_count = 0, n_compared = 0, seed = 33649;
   spram_ctrl spram_ctrl_inst
   (
      .clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
      .req_sel_mode(req_sel_mode), .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
      .rsp_rdata(rsp_rdata), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .ram_select_n(ram_select_n),
      .write_strobe_n(write_strobe_n), .mem_rdata(mem_rdata)
   );
   spram_sram_model spram_sram_model_inst
   (
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .ram_select_n(ram_select_n),
      .write_strobe_n(write_strobe_n), .mem_rdata(mem_rdata)
   );
   // cycles from the taking edge to the response
   function automatic int exp_lat(logic w);
      return w ? SPRAM_SETUP_CYC + SPRAM_STROBE_CYC + SPRAM_HOLD_CYC : SPRAM_SETUP_CYC + SPRAM_ACCESS_CYC;
   endfunction
   initial forever #20 clk = ~clk;
   task check(string s, logic [SPRAM_WIDTH-1:0] e, g);
      n_compared++;
      if (g !== e)
      begin
         bad_count++;
         $display("Error %s expected %h seen %h", s, e, g);
      end
   endtask
   task complete_run;
      $display("checks %0d bad %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task xfer(logic w, s, logic [SPRAM_AW-1:0] a, logic [SPRAM_WIDTH-1:0] d);
      int n;
      {req_valid, req_write, req_sel_mode, req_addr, req_wdata} <= {1'h1, w, s, a, d};
      @(posedge clk);
      req_valid <= 1'h0;
      n = 0;
      while (rsp_valid !== 1'h1 && n < 8)
      begin
         @(negedge clk);
         n++;
      end
      check("rsp_valid", 1'h1, rsp_valid);
      check("rsp_latency", exp_lat(w), n - 1);
      if (!w && ref_q.exists(a))
         check("rsp_rdata", ref_q[a], rsp_rdata);
      if (w)
         ref_q[a] = d;
      @(posedge clk);
   endtask
   initial
   begin
      repeat (5) @(posedge clk);
      rst_n <= 1'h1;
      @(posedge clk);
      xfer(1'h1, 1'h1, '1, '1);
      xfer(1'h0, 1'h0, '1, '0);
      $display("corner test done");
      repeat (60)
         xfer(1'($random(seed)), 1'($random(seed)), SPRAM_AW'(3'($random(seed))),
            SPRAM_WIDTH'({$random(seed), $random(seed), $random(seed)}));
      $display("random test done");
      // reset in the middle of a read, then the corner word read select-timed
      req_valid <= 1'h1;
      req_write <= 1'h0;
      @(posedge clk);
      req_valid <= 1'h0;
      @(posedge clk);
      rst_n <= 1'h0;
      @(negedge clk);
      check("ram_select_n", 1'h1, ram_select_n);
      check("write_strobe_n", 1'h1, write_strobe_n);
      check("rsp_valid", 1'h0, rsp_valid);
      check("req_ready", 1'h1, req_ready);
      check("rsp_rdata", '0, rsp_rdata);
      @(posedge clk);
      rst_n <= 1'h1;
      @(posedge clk);
      xfer(1'h0, 1'h1, '1, '0);
      $display("reset test done");
      complete_run();
   end
   initial
   begin
      repeat (3000) @(posedge clk);
      bad_count++;
      complete_run();
   end
endmodule
